// file: fsg_pkg.sv
// constants, types and lookup for the telegram gateway
package fsg_pkg;
	localparam int CNT_W = 16;
	localparam int LEN_W = 11;
	localparam int RING_DEPTH = 1024;
	localparam int LENQ_DEPTH = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_CFGLEN = 8'h08;
	localparam logic [7:0] REG_COLLFILL = 8'h0c;
	localparam logic [7:0] REG_CMDFILL = 8'h10;
	localparam logic [7:0] REG_SERFRM = 8'h14;
	localparam logic [7:0] REG_FRMERR = 8'h18;
	localparam logic [7:0] REG_BADCMD = 8'h1c;
	localparam logic [7:0] REG_FBSENT = 8'h20;
	localparam logic [7:0] REG_SEROK = 8'h24;
	localparam logic [7:0] REG_SERFAIL = 8'h28;
	localparam logic [7:0] REG_MEMLAST = 8'h2c;
	localparam logic [7:0] REG_SERCFG = 8'h30;
	localparam int CTRL_TRANSP = 0;
	localparam int CTRL_MEMMODE = 1;
	localparam int STATUS_LOSS = 5;
	localparam logic [7:0] CFGLEN_RST = 8'h08;
	localparam logic [1:0] HDR_BYTES = 2'h2;
	localparam logic [7:0] CHAR_STX = 8'h02;
	localparam logic [7:0] CHAR_CR = 8'h0d;
	localparam logic [7:0] CHAR_LF = 8'h0a;
	localparam logic [7:0] CHAR_NONE = 8'h00;
	localparam logic [7:0] CMD_MEM = 8'h53;
	localparam logic [7:0] CMD_VER = 8'h56;
	localparam logic [7:0] CMD_INFO = 8'h49;
	localparam logic [3:0] BAUD_9600 = 4'h0;
	localparam logic [3:0] BAUD_57600 = 4'h1;
	localparam logic [2:0] FMT_8N1 = 3'h0;

	typedef enum logic [1:0] {SVC_RUN = 2'b00, SVC_DEV = 2'b01, SVC_MA = 2'b10} fsg_svc_t;
	typedef enum logic [2:0] {FT_IDLE = 3'b000, FT_HDR0 = 3'b001, FT_HDR1 = 3'b010,
		FT_DATA = 3'b011, FT_DROP = 3'b100} fsg_ft_t;
	typedef enum logic [2:0] {ST_IDLE = 3'b000, ST_START = 3'b001, ST_DATA = 3'b010,
		ST_END1 = 3'b011, ST_END2 = 3'b100} fsg_st_t;

	typedef struct packed {
		logic toggle;
		logic [4:0] addr;
		logic bcast;
		logic cmdMode;
	} fsg_ctrl0_t;

	typedef struct packed {
		logic toggle;
		logic rsv6;
		logic loss;
		logic rsv4;
		logic rsv3;
		logic service_mode_flag;
		logic rsv1;
		logic rsv0;
	} fsg_stat0_t;

	typedef struct packed {
		logic valid;
		logic first;
		logic last;
		logic err;
		logic [7:0] data;
	} fsg_byte_t;

	typedef struct packed {
		logic [7:0] start;
		logic [7:0] end1;
		logic [7:0] end2;
		logic [3:0] baud;
		logic [2:0] format;
	} fsg_sercfg_t;

	typedef struct packed {
		logic transp;
		logic [7:0] cfgLen;
		logic loss;
		logic toggle;
		logic service_mode_flag;
		logic memMode;
		fsg_ctrl0_t ctrl0;
		logic lastPlcToggle;
		logic [1:0] fbIdx;
		logic fbFwd;
		logic [7:0] fbPay;
		fsg_ft_t ft;
		logic [LEN_W-1:0] txLen;
		logic [7:0] txSent;
		logic [7:0] lenCode;
		fsg_st_t st;
		logic serInFrame;
		logic [LEN_W-1:0] serLen;
		logic [CNT_W-1:0] cSerFrm;
		logic [CNT_W-1:0] cFrmErr;
		logic [CNT_W-1:0] cBadCmd;
		logic [CNT_W-1:0] cFbSent;
		logic [CNT_W-1:0] cSerOk;
		logic [CNT_W-1:0] cSerFail;
		logic [LEN_W-1:0] memSerLen;
		logic [7:0] memFbLen;
		fsg_sercfg_t serCfg;
		logic cfgTaken;
		logic [31:0] rdData;
	} fsg_gw_state_t;

	// framing and line settings per end-device switch position
	function automatic fsg_sercfg_t fsg_sercfg_f(input logic [3:0] pos);
		fsg_sercfg_t c;
		c.start = CHAR_STX;
		c.end1 = CHAR_CR;
		c.end2 = CHAR_LF;
		c.baud = BAUD_9600;
		c.format = FMT_8N1;
		if (pos == 4'h4 || pos == 4'h5 || pos == 4'h7 || pos == 4'hb)
			c.baud = BAUD_57600;
		if (pos == 4'h8)
			c.end2 = CHAR_NONE;
		return c;
	endfunction
endpackage

// file: fsg_ring.sv
// flip-flop ring memory with fill level
`timescale 1ns/1ps
`default_nettype none
module fsg_ring #(
	parameter int W = 8,
	parameter int D = 1024,
	parameter int AW = $clog2(D)
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic pushValid,
	input wire logic [W-1:0] pushData,
	output logic pushReady,
	input wire logic popReady,
	output logic popValid,
	output logic [W-1:0] popData,
	output logic [AW:0] fill
);
	localparam logic [AW-1:0] LAST_IDX = AW'(D - 1);
	localparam logic [AW:0] FULL_CNT = (AW + 1)'(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wrIdx;
		logic [AW-1:0] rdIdx;
		logic [AW:0] cnt;
	} fsg_ring_state_t;
	fsg_ring_state_t s_r;
	fsg_ring_state_t s_nxt;
	logic doPush;
	logic doPop;

	assign pushReady = s_r.cnt != FULL_CNT;
	assign popValid = s_r.cnt != '0;
	assign popData = s_r.mem[s_r.rdIdx];
	assign fill = s_r.cnt;
	assign doPush = pushValid && pushReady;
	assign doPop = popValid && popReady;

	always_comb
	begin
		s_nxt = s_r;
		if (doPush)
		begin
			s_nxt.mem[s_r.wrIdx] = pushData;
			s_nxt.wrIdx = (s_r.wrIdx == LAST_IDX) ? '0 : s_r.wrIdx + 1'b1;
		end
		if (doPop)
			s_nxt.rdIdx = (s_r.rdIdx == LAST_IDX) ? '0 : s_r.rdIdx + 1'b1;
		if (doPush && !doPop)
			s_nxt.cnt = s_r.cnt + 1'b1;
		else if (doPop && !doPush)
			s_nxt.cnt = s_r.cnt - 1'b1;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end
endmodule
`default_nettype wire

// file: fsg_gateway.sv
// telegram framing core of the fieldbus to serial gateway
// Notes on behaviour
// - telegram: two control bytes in, two status bytes out, payload from byte three.
// - payload longer than configured length is cut; only leading part is sent.
// - any such truncation sets the data-loss flag in status byte zero.
// - status byte zero: service flag bit 2, loss bit 5, toggle bit 7.
// - status byte one carries the eight-bit payload length code.
// - toggle bit in status byte zero is driven only in transparent mode.
// - serial side gets payload only, wrapped in start and end characters.
// - control bytes are consumed here and never forwarded.
// - serial-to-fieldbus data sits in a 1024-byte ring with visible fill.
// - fieldbus-to-serial data sits in its own 1024-byte ring with visible fill.
// - count every serial frame received; code counts only frames closed by end1, not those cut short.
// - count every serial framing error.
// - count every unrecognised service command.
// - count fieldbus frames sent, serial frames sent and serial frames failed.
// - start, end characters, baud and format follow the device switch.
// - service port routes to device or gateway only in those positions.
// - memory command enables keeping the last frame lengths of both sides.
// - service flag is set in either service position, cleared in normal run.
// - toggle inverts for every data set sent to the PLC.
// - length code equals payload bytes that follow, reset to zero.
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module fsg_gateway #(
	parameter int RING_D = fsg_pkg::RING_DEPTH,
	parameter int LENQ_D = fsg_pkg::LENQ_DEPTH
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	input wire fsg_pkg::fsg_byte_t fbRx,
	output fsg_pkg::fsg_byte_t fbTx,
	input wire logic fbTxReady,
	input wire fsg_pkg::fsg_byte_t serRx,
	output fsg_pkg::fsg_byte_t serTx,
	input wire logic serTxReady,
	input wire logic [3:0] endDevSelect,
	input wire fsg_pkg::fsg_svc_t svcSel,
	input wire fsg_pkg::fsg_byte_t svcCmd,
	output logic svcToDevice,
	output logic svcToGateway,
	output fsg_pkg::fsg_sercfg_t serCfg
);
	localparam int RAW = $clog2(RING_D);
	localparam logic [1:0] HDR_IDX = fsg_pkg::HDR_BYTES;
	fsg_pkg::fsg_gw_state_t s_r;
	fsg_pkg::fsg_gw_state_t s_nxt;
	fsg_pkg::fsg_stat0_t stat0;
	logic collPush, collPushRdy, collPop, collPopVld;
	logic [7:0] collData;
	logic [RAW:0] collFill;
	logic lenPush, lenPushRdy, lenPop, lenPopVld;
	logic [fsg_pkg::LEN_W-1:0] lenData;
	logic cmdPush, cmdPop, cmdPopVld;
	logic [8:0] cmdPushData, cmdData;
	logic [RAW:0] cmdFill;
	logic [fsg_pkg::LEN_W-1:0] cfgLen11;
	logic [RAW:0] cmdFree;
	logic ftEnd, ftLast;

	fsg_ring #(.W(8), .D(RING_D)) collRing (.clk(clk), .nrst(nrst),
		.pushValid(collPush), .pushData(serRx.data), .pushReady(collPushRdy),
		.popReady(collPop), .popValid(collPopVld), .popData(collData), .fill(collFill));
	fsg_ring #(.W(fsg_pkg::LEN_W), .D(LENQ_D)) lenRing (.clk(clk), .nrst(nrst),
		.pushValid(lenPush), .pushData(s_r.serLen), .pushReady(lenPushRdy),
		.popReady(lenPop), .popValid(lenPopVld), .popData(lenData), .fill());
	fsg_ring #(.W(9), .D(RING_D)) cmdRing (.clk(clk), .nrst(nrst),
		.pushValid(cmdPush), .pushData(cmdPushData), .pushReady(),
		.popReady(cmdPop), .popValid(cmdPopVld), .popData(cmdData), .fill(cmdFill));

	assign cfgLen11 = {3'h0, s_r.cfgLen};
	assign cmdFree = (RAW + 1)'(RING_D) - cmdFill;
	assign regRdata = s_r.rdData;
	assign serCfg = s_r.serCfg;
	assign svcToDevice = svcSel == fsg_pkg::SVC_DEV;
	assign svcToGateway = svcSel == fsg_pkg::SVC_MA;

	always_comb
	begin
		stat0 = '0;
		stat0.service_mode_flag = s_r.service_mode_flag;
		stat0.loss = s_r.loss;
		stat0.toggle = s_r.toggle && s_r.transp;
	end

	// outputs toward the PLC and the end device
	always_comb
	begin
		fbTx = '0;
		ftLast = 1'b0;
		case (s_r.ft)
			fsg_pkg::FT_HDR0:
			begin
				fbTx.valid = 1'b1;
				fbTx.first = 1'b1;
				fbTx.data = stat0;
			end
			fsg_pkg::FT_HDR1:
			begin
				fbTx.valid = 1'b1;
				ftLast = s_r.lenCode == '0;
				fbTx.last = ftLast;
				fbTx.data = s_r.lenCode;
			end
			fsg_pkg::FT_DATA:
			begin
				fbTx.valid = collPopVld;
				ftLast = s_r.txSent == s_r.lenCode - 1'b1;
				fbTx.last = ftLast;
				fbTx.data = collData;
			end
			default:
				fbTx = '0;
		endcase
		serTx = '0;
		case (s_r.st)
			fsg_pkg::ST_START:
			begin
				serTx.valid = 1'b1;
				serTx.first = 1'b1;
				serTx.data = s_r.serCfg.start;
			end
			fsg_pkg::ST_DATA:
			begin
				serTx.valid = cmdPopVld;
				serTx.data = cmdData[7:0];
			end
			fsg_pkg::ST_END1:
			begin
				serTx.valid = 1'b1;
				serTx.last = s_r.serCfg.end2 == fsg_pkg::CHAR_NONE;
				serTx.data = s_r.serCfg.end1;
			end
			fsg_pkg::ST_END2:
			begin
				serTx.valid = 1'b1;
				serTx.last = 1'b1;
				serTx.data = s_r.serCfg.end2;
			end
			default:
				serTx = '0;
		endcase
	end

	always_comb
	begin
		s_nxt = s_r;
		collPush = 1'b0;
		lenPush = 1'b0;
		lenPop = 1'b0;
		collPop = 1'b0;
		cmdPush = 1'b0;
		cmdPop = 1'b0;
		cmdPushData = {fbRx.last, fbRx.data};
		ftEnd = 1'b0;
		if (!s_r.cfgTaken)
		begin
			s_nxt.serCfg = fsg_pkg::fsg_sercfg_f(endDevSelect);
			s_nxt.cfgTaken = 1'b1;
		end
		s_nxt.service_mode_flag = svcSel != fsg_pkg::SVC_RUN;
		// register writes; hardware sets below win over the loss clear
		if (regWr)
		begin
			if (regAddr == fsg_pkg::REG_CTRL)
			begin
				s_nxt.transp = regWdata[fsg_pkg::CTRL_TRANSP];
				s_nxt.memMode = regWdata[fsg_pkg::CTRL_MEMMODE];
			end
			else if (regAddr == fsg_pkg::REG_STATUS)
			begin
				if (regWdata[fsg_pkg::STATUS_LOSS])
					s_nxt.loss = 1'b0;
			end
			else if (regAddr == fsg_pkg::REG_CFGLEN)
				s_nxt.cfgLen = regWdata[7:0];
		end
		// service commands from the gateway service port
		if (svcCmd.valid && svcToGateway)
		begin
			if (svcCmd.data == fsg_pkg::CMD_MEM)
				s_nxt.memMode = 1'b1;
			else if (svcCmd.data != fsg_pkg::CMD_VER && svcCmd.data != fsg_pkg::CMD_INFO
				&& svcCmd.data != fsg_pkg::CHAR_STX && svcCmd.data != fsg_pkg::CHAR_CR
				&& svcCmd.data != fsg_pkg::CHAR_LF)
				s_nxt.cBadCmd = s_r.cBadCmd + 1'b1;
		end
		// serial receive into the collective ring
		if (serRx.valid)
		begin
			if (serRx.err)
			begin
				s_nxt.cFrmErr = s_r.cFrmErr + 1'b1;
				if (s_r.serInFrame)
				begin
					lenPush = 1'b1;
					s_nxt.serInFrame = 1'b0;
				end
			end
			else if (serRx.data == s_r.serCfg.start)
			begin
				if (s_r.serInFrame)
					lenPush = 1'b1;
				s_nxt.serInFrame = lenPushRdy || s_r.serInFrame;
				s_nxt.serLen = '0;
				if (!lenPushRdy && !s_r.serInFrame)
					s_nxt.loss = 1'b1;
			end
			else if (s_r.serInFrame && serRx.data == s_r.serCfg.end1)
			begin
				lenPush = 1'b1;
				s_nxt.serInFrame = 1'b0;
				s_nxt.cSerFrm = s_r.cSerFrm + 1'b1;
				if (s_r.memMode)
					s_nxt.memSerLen = s_r.serLen;
			end
			else if (s_r.serInFrame)
			begin
				collPush = 1'b1;
				if (collPushRdy)
					s_nxt.serLen = s_r.serLen + 1'b1;
				else
					s_nxt.loss = 1'b1;
			end
		end
		// fieldbus transmit toward the PLC
		case (s_r.ft)
			fsg_pkg::FT_IDLE:
				if (lenPopVld)
				begin
					lenPop = 1'b1;
					s_nxt.txLen = lenData;
					s_nxt.txSent = '0;
					s_nxt.ft = fsg_pkg::FT_HDR0;
					if (lenData > cfgLen11)
					begin
						s_nxt.lenCode = s_r.cfgLen;
						s_nxt.loss = 1'b1;
					end
					else
						s_nxt.lenCode = lenData[7:0];
				end
			fsg_pkg::FT_HDR0:
				if (fbTxReady)
					s_nxt.ft = fsg_pkg::FT_HDR1;
			fsg_pkg::FT_HDR1:
				if (fbTxReady)
				begin
					ftEnd = ftLast;
					if (!ftLast)
						s_nxt.ft = fsg_pkg::FT_DATA;
					else if (s_r.txLen != '0)
						s_nxt.ft = fsg_pkg::FT_DROP;
					else
						s_nxt.ft = fsg_pkg::FT_IDLE;
				end
			fsg_pkg::FT_DATA:
				if (fbTxReady && collPopVld)
				begin
					collPop = 1'b1;
					s_nxt.txSent = s_r.txSent + 1'b1;
					s_nxt.txLen = s_r.txLen - 1'b1;
					if (ftLast)
					begin
						ftEnd = 1'b1;
						s_nxt.ft = (s_r.txLen == 1'b1) ? fsg_pkg::FT_IDLE : fsg_pkg::FT_DROP;
					end
				end
			fsg_pkg::FT_DROP:
				if (collPopVld)
				begin
					collPop = 1'b1;
					s_nxt.txLen = s_r.txLen - 1'b1;
					if (s_r.txLen == 1'b1)
						s_nxt.ft = fsg_pkg::FT_IDLE;
				end
			default:
				s_nxt.ft = fsg_pkg::FT_IDLE;
		endcase
		if (ftEnd)
		begin
			s_nxt.toggle = !s_r.toggle;
			s_nxt.cFbSent = s_r.cFbSent + 1'b1;
			if (s_r.memMode)
				s_nxt.memFbLen = s_r.lenCode;
		end
		// fieldbus receive from the PLC
		if (fbRx.valid)
		begin
			if (s_r.fbIdx == '0)
			begin
				s_nxt.ctrl0 = fbRx.data;
				s_nxt.lastPlcToggle = fbRx.data[7];
				s_nxt.fbFwd = fbRx.data[0] || (fbRx.data[7] != s_r.lastPlcToggle);
				s_nxt.fbPay = '0;
			end
			else if (s_r.fbIdx == HDR_IDX && s_r.fbFwd)
			begin
				if (s_r.fbPay == '0 && cmdFree <= {3'h0, s_r.cfgLen})
				begin
					s_nxt.fbFwd = 1'b0;
					s_nxt.cSerFail = s_r.cSerFail + 1'b1;
				end
				else if (s_r.fbPay < s_r.cfgLen)
				begin
					cmdPush = 1'b1;
					cmdPushData[8] = fbRx.last || (s_r.fbPay == s_r.cfgLen - 1'b1);
					s_nxt.fbPay = s_r.fbPay + 1'b1;
				end
				else
					s_nxt.loss = 1'b1;
			end
			if (fbRx.last)
				s_nxt.fbIdx = '0;
			else if (s_r.fbIdx != HDR_IDX)
				s_nxt.fbIdx = s_r.fbIdx + 1'b1;
		end
		// serial transmit toward the end device
		case (s_r.st)
			fsg_pkg::ST_IDLE:
				if (cmdPopVld)
					s_nxt.st = fsg_pkg::ST_START;
			fsg_pkg::ST_START:
				if (serTxReady)
					s_nxt.st = fsg_pkg::ST_DATA;
			fsg_pkg::ST_DATA:
				if (serTxReady && cmdPopVld)
				begin
					cmdPop = 1'b1;
					if (cmdData[8])
						s_nxt.st = fsg_pkg::ST_END1;
				end
			fsg_pkg::ST_END1:
				if (serTxReady)
				begin
					if (s_r.serCfg.end2 != fsg_pkg::CHAR_NONE)
						s_nxt.st = fsg_pkg::ST_END2;
					else
					begin
						s_nxt.st = fsg_pkg::ST_IDLE;
						s_nxt.cSerOk = s_r.cSerOk + 1'b1;
					end
				end
			fsg_pkg::ST_END2:
				if (serTxReady)
				begin
					s_nxt.st = fsg_pkg::ST_IDLE;
					s_nxt.cSerOk = s_r.cSerOk + 1'b1;
				end
			default:
				s_nxt.st = fsg_pkg::ST_IDLE;
		endcase
		// register reads
		s_nxt.rdData = '0;
		if (regRd)
		begin
			if (regAddr == fsg_pkg::REG_CTRL)
				s_nxt.rdData = {30'h0, s_r.memMode, s_r.transp};
			else if (regAddr == fsg_pkg::REG_STATUS)
				s_nxt.rdData = {8'h0, s_r.ctrl0, s_r.lenCode, stat0};
			else if (regAddr == fsg_pkg::REG_CFGLEN)
				s_nxt.rdData = {24'h0, s_r.cfgLen};
			else if (regAddr == fsg_pkg::REG_COLLFILL)
				s_nxt.rdData = 32'(collFill);
			else if (regAddr == fsg_pkg::REG_CMDFILL)
				s_nxt.rdData = 32'(cmdFill);
			else if (regAddr == fsg_pkg::REG_SERFRM)
				s_nxt.rdData = {16'h0, s_r.cSerFrm};
			else if (regAddr == fsg_pkg::REG_FRMERR)
				s_nxt.rdData = {16'h0, s_r.cFrmErr};
			else if (regAddr == fsg_pkg::REG_BADCMD)
				s_nxt.rdData = {16'h0, s_r.cBadCmd};
			else if (regAddr == fsg_pkg::REG_FBSENT)
				s_nxt.rdData = {16'h0, s_r.cFbSent};
			else if (regAddr == fsg_pkg::REG_SEROK)
				s_nxt.rdData = {16'h0, s_r.cSerOk};
			else if (regAddr == fsg_pkg::REG_SERFAIL)
				s_nxt.rdData = {16'h0, s_r.cSerFail};
			else if (regAddr == fsg_pkg::REG_MEMLAST)
				s_nxt.rdData = {13'h0, s_r.memSerLen, s_r.memFbLen};
			else if (regAddr == fsg_pkg::REG_SERCFG)
				s_nxt.rdData = {1'b0, s_r.serCfg};
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_r <= '0;
			s_r.cfgLen <= fsg_pkg::CFGLEN_RST;
		end
		else
			s_r <= s_nxt;
	end
endmodule
`default_nettype wire

// file: fsg_gateway_props.sv
// port assertions for the telegram gateway
`timescale 1ns/1ps
`default_nettype none
module fsg_gateway_props #(
	parameter int RING_D = 1024,
	parameter int LENQ_D = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire fsg_pkg::fsg_byte_t fbTx,
	input wire logic fbTxReady,
	input wire fsg_pkg::fsg_byte_t serTx,
	input wire logic serTxReady,
	input wire fsg_pkg::fsg_svc_t svcSel,
	input wire logic svcToDevice,
	input wire logic svcToGateway,
	input wire fsg_pkg::fsg_sercfg_t serCfg
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	AST_FB_HOLD: assert property (fbTx.valid && !fbTxReady |=> $stable(fbTx))
		else $error("fieldbus byte changed while stalled");
	AST_FB_NEXT: assert property (fbTx.valid && fbTx.last && fbTxReady |=> !fbTx.valid || fbTx.first)
		else $error("telegram not restarted at status byte");
	AST_STAT1: assert property (fbTx.valid && fbTx.first && fbTxReady |=> ##[0:3] (fbTx.valid && !fbTx.first))
		else $error("length byte missing after status byte");
	AST_STAT_RSV: assert property (fbTx.valid && fbTx.first |-> (fbTx.data & 8'h5b) == 8'h00)
		else $error("reserved status bit set");
	AST_SMA: assert property (fbTx.valid && fbTx.first |-> fbTx.data[2] == (svcSel != fsg_pkg::SVC_RUN))
		else $error("service flag wrong");
	AST_ROUTE: assert property (svcToDevice == (svcSel == fsg_pkg::SVC_DEV) && svcToGateway == (svcSel == fsg_pkg::SVC_MA))
		else $error("service routing wrong");
	AST_SER_START: assert property (serTx.valid && serTx.first |-> serTx.data == serCfg.start)
		else $error("serial frame start wrong");
	AST_SER_END: assert property (serTx.valid && serTx.last |-> serTx.data == ((serCfg.end2 != 8'h00) ? serCfg.end2 : serCfg.end1))
		else $error("serial frame end wrong");
	AST_SER_HOLD: assert property (serTx.valid && !serTxReady |=> $stable(serTx))
		else $error("serial byte changed while stalled");
endmodule
bind fsg_gateway fsg_gateway_props #(.RING_D(RING_D), .LENQ_D(LENQ_D)) u_props (.clk(clk),
	.nrst(nrst), .fbTx(fbTx), .fbTxReady(fbTxReady), .serTx(serTx), .serTxReady(serTxReady),
	.svcSel(svcSel), .svcToDevice(svcToDevice), .svcToGateway(svcToGateway), .serCfg(serCfg));
`default_nettype wire

// file: fsg_end_dev.sv
// serial end device model
`timescale 1ns/1ps
`default_nettype none
module fsg_end_dev (
	input wire logic clk,
	input wire logic nrst,
	input wire fsg_pkg::fsg_byte_t serTx,
	output logic serTxReady,
	output fsg_pkg::fsg_byte_t serRx
);
	int seed = 2167;
	logic slow = 1'b0;
	initial
	begin
		serRx = 12'h000;
		serTxReady = 1'b1;
	end
	// accepts promptly or stalls at random
	always @(posedge clk)
		serTxReady <= (!nrst || !slow || !serTx.valid) ? 1'b1 : 1'($random(seed));
	// one byte, then an idle cycle with the line inverted
	task automatic put(input logic [7:0] d, input logic e);
		serRx <= {3'h4, e, d};
		@(posedge clk);
		serRx <= {4'h0, ~d};
		@(posedge clk);
	endtask
	// start char, payload, end char
	task automatic frame(input logic [7:0] p[$]);
		put(8'h02, 1'b0);
		foreach (p[i])
			put(p[i], 1'b0);
		put(8'h0d, 1'b0);
	endtask
endmodule
`default_nettype wire

// file: fsg_gateway_tb.sv
// self-checking bench for the telegram gateway
`timescale 1ns/1ps
`default_nettype none
module fsg_gateway_tb;
	typedef struct packed {logic [31:0] v; logic [31:0] m;} fsg_exp_t;
	localparam fsg_exp_t expNone = {32'hxxxxxxxx, 32'hffffffff};
	logic clk, fbTxReady = 1'b1, serTxReady, svcToDevice, svcToGateway, rdPend = 1'b0;
	logic nrst = 1'b0, regWr = 1'b0, regRd = 1'b0, transp = 1'b0, tgl = 1'b0, service_mode_flag = 1'b0;
	logic lastT = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0, regRdata, ex;
	logic [3:0] endDevSelect = 4'h0;
	fsg_pkg::fsg_byte_t fbRx = 12'h000, svcCmd = 12'h000, fbTx, serRx, serTx;
	fsg_pkg::fsg_svc_t svcSel = fsg_pkg::SVC_RUN;
	fsg_pkg::fsg_sercfg_t serCfg;
	fsg_exp_t regQ[$], fbQ[$], serQ[$];
	int error_cnt = 0, checks = 0, seed = 2167, cl = 8, mode = 0;
	fsg_gateway #(.RING_D(16), .LENQ_D(8)) dut (.clk(clk), .nrst(nrst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .fbRx(fbRx),
		.fbTx(fbTx), .fbTxReady(fbTxReady), .serRx(serRx), .serTx(serTx),
		.serTxReady(serTxReady), .endDevSelect(endDevSelect), .svcSel(svcSel), .svcCmd(svcCmd),
		.svcToDevice(svcToDevice), .svcToGateway(svcToGateway), .serCfg(serCfg));
	fsg_end_dev dev (.clk(clk), .nrst(nrst), .serTx(serTx), .serTxReady(serTxReady),
		.serRx(serRx));
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial
	begin
		#1000000;
		error_cnt++;
		$display("wrong value at %0t: watchdog expired", $time);
		finish_test();
	end
	always @(posedge clk)
		fbTxReady <= mode == 0 ? 1'b1 : mode == 1 ? 1'($random(seed)) : 1'b0;
	task automatic chk(input logic [31:0] g, input fsg_exp_t e);
		checks++;
		if (((g ^ e.v) & e.m) !== 32'h0)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h want %h", $time, g, e.v);
		end
	endtask
	// watcher: compares each result with the oldest note
	always @(posedge clk)
	begin
		if (rdPend)
			chk(regRdata, regQ.size() ? regQ.pop_front() : expNone);
		rdPend = regRd;
		if (fbTx.valid && fbTxReady)
			chk({24'h0, fbTx.data}, fbQ.size() ? fbQ.pop_front() : expNone);
		if (serTx.valid && serTxReady)
			chk({24'h0, serTx.data}, serQ.size() ? serQ.pop_front() : expNone);
	end
	task automatic finish_test;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic drain;
		int t;
		t = 0;
		while (fbQ.size() + serQ.size() + regQ.size() != 0 && t < 400)
		begin
			@(posedge clk);
			t++;
		end
		if (t == 400)
			chk(32'h0, expNone);
		repeat (4) @(posedge clk);
	endtask
	task automatic rst(input logic [3:0] p);
		endDevSelect <= p;
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
		regQ.push_back({v, m});
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic cmd(input logic [7:0] c);
		logic [7:0] m[4];
		m = '{fsg_pkg::CHAR_STX, c, fsg_pkg::CHAR_CR, fsg_pkg::CHAR_LF};
		foreach (m[i])
		begin
			svcCmd <= {4'h8, m[i]};
			@(posedge clk);
			svcCmd <= {4'h0, ~m[i]};
			@(posedge clk);
		end
	endtask
	// serial frame of n bytes, expected telegram toward the plc
	task automatic sfr(input int n, input logic lv, input logic lm);
		logic [7:0] p[$];
		int k;
		k = n < cl ? n : cl;
		fbQ.push_back({24'h0, transp & tgl, 1'b0, lv, 2'h0, service_mode_flag, 2'h0, 24'h0, 2'h3, lm, 5'h1f});
		fbQ.push_back({24'h0, 8'(k), 32'hff});
		for (int i = 0; i < n; i++)
			p.push_back(8'h20 + 8'($random(seed) & 63));
		for (int i = 0; i < k; i++)
			fbQ.push_back({24'h0, p[i], 32'hff});
		tgl = ~tgl;
		dev.frame(p);
		if (mode != 2)
			drain();
	endtask
	// plc telegram: control bytes, then n payload bytes
	task automatic tel(input logic [7:0] c0, input int n);
		logic [7:0] d;
		logic fwd;
		fwd = c0[0] | (c0[7] != lastT);
		lastT = c0[7];
		if (cl >= 16)
			fwd = 1'b0;
		if (fwd)
			serQ.push_back({24'h0, 8'h02, 32'hff});
		for (int i = 0; i < n + 2; i++)
		begin
			d = i == 0 ? c0 : 8'($random(seed));
			fbRx <= {1'b1, i == 0, i == n + 1, 1'b0, d};
			if (fwd && i > 1 && i - 2 < cl)
				serQ.push_back({24'h0, d, 32'hff});
			@(posedge clk);
		end
		fbRx <= {4'h0, ~d};
		for (int i = 0; i < 2; i++)
			if (fwd)
				serQ.push_back({24'h0, i == 0 ? 8'h0d : 8'h0a, 32'hff});
		drain();
	endtask
	initial
	begin
		for (int p = 0; p < 16; p++)
		begin
			rst(4'(p));
			ex = {9'h002, 8'h0d, p == 8 ? 8'h00 : 8'h0a, 4'(p == 4 || p == 5 || p == 7 || p == 11), 3'h0};
			chk({1'b0, serCfg}, {ex, 32'hffffffff});
		end
		rst(4'h4);
		rd(fsg_pkg::REG_CFGLEN, 32'h8, 32'hffffffff);
		rd(fsg_pkg::REG_STATUS, 32'h0, 32'hffffffff);
		rd(8'hfc, 32'h0, 32'hffffffff);
		cl = 3;
		wr(fsg_pkg::REG_CFGLEN, 32'h3);
		sfr(2, 1'b0, 1'b1);
		transp = 1'b1;
		wr(fsg_pkg::REG_CTRL, 32'h1);
		sfr(3, 1'b0, 1'b1);
		sfr(5, 1'b0, 1'b0);
		sfr(1, 1'b1, 1'b1);
		rd(fsg_pkg::REG_STATUS, 32'h0120, 32'hff20);
		wr(fsg_pkg::REG_STATUS, 32'h20);
		dev.put(8'h41, 1'b1);
		sfr(2, 1'b0, 1'b1);
		mode = 2;
		sfr(3, 1'b0, 1'b1);
		rd(fsg_pkg::REG_COLLFILL, 32'h3, 32'hffffffff);
		mode = 1;
		drain();
		rd(fsg_pkg::REG_COLLFILL, 32'h0, 32'hffffffff);
		svcSel <= fsg_pkg::SVC_MA;
		service_mode_flag = 1'b1;
		repeat (4) @(posedge clk);
		sfr(2, 1'b0, 1'b1);
		cmd(fsg_pkg::CMD_MEM);
		cmd(8'h5a);
		rd(fsg_pkg::REG_CTRL, 32'h3, 32'h3);
		rd(fsg_pkg::REG_BADCMD, 32'h1, 32'hffffffff);
		transp = 1'b0;
		wr(fsg_pkg::REG_CTRL, 32'h2);
		sfr(4, 1'b0, 1'b0);
		rd(fsg_pkg::REG_MEMLAST, 32'h0403, 32'hffffffff);
		wr(fsg_pkg::REG_STATUS, 32'h20);
		svcSel <= fsg_pkg::SVC_DEV;
		repeat (4) @(posedge clk);
		svcSel <= fsg_pkg::SVC_RUN;
		service_mode_flag = 1'b0;
		repeat (4) @(posedge clk);
		rd(fsg_pkg::REG_SERFRM, 32'h8, 32'hffffffff);
		rd(fsg_pkg::REG_FRMERR, 32'h1, 32'hffffffff);
		rd(fsg_pkg::REG_FBSENT, 32'h8, 32'hffffffff);
		dev.slow <= 1'b1;
		tel(8'h01, 2);
		tel(8'h80, 3);
		tel(8'h80, 2);
		tel(8'hfe, 1);
		tel(8'h00, 5);
		rd(fsg_pkg::REG_SEROK, 32'h3, 32'hffffffff);
		rd(fsg_pkg::REG_STATUS, 32'h20, 32'hff0020);
		rd(fsg_pkg::REG_CMDFILL, 32'h0, 32'hffffffff);
		cl = 16;
		wr(fsg_pkg::REG_CFGLEN, 32'h10);
		tel(8'h01, 2);
		rd(fsg_pkg::REG_SERFAIL, 32'h1, 32'hffffffff);
		drain();
		finish_test();
	end
endmodule
`default_nettype wire
